// ### verilog/pdma_pkg.sv
// register map, field positions and reset values of the dma channel control
package pdma_pkg;
  localparam logic [7:0]  OFF_RX_ADDR      = 8'h00;
  localparam logic [7:0]  OFF_RX_COUNT     = 8'h04;
  localparam logic [7:0]  OFF_TX_ADDR      = 8'h08;
  localparam logic [7:0]  OFF_TX_COUNT     = 8'h0C;
  localparam logic [7:0]  OFF_NEXT_RX_ADDR = 8'h10;
  localparam logic [7:0]  OFF_NEXT_RX_CNT  = 8'h14;
  localparam logic [7:0]  OFF_NEXT_TX_ADDR = 8'h18;
  localparam logic [7:0]  OFF_NEXT_TX_CNT  = 8'h1C;
  localparam logic [7:0]  OFF_COMMAND      = 8'h20;
  localparam logic [7:0]  OFF_STATUS       = 8'h24;
  localparam logic [7:0]  OFF_MODE         = 8'h28;
  localparam int          BIT_RX_EN        = 0;
  localparam int          BIT_RX_DIS       = 1;
  localparam int          BIT_TX_EN        = 8;
  localparam int          BIT_TX_DIS       = 9;
  localparam int          BIT_HALF_DUPLEX  = 0;
  localparam logic [31:0] RST_ADDR         = 32'h0000_0000;
  localparam logic [15:0] RST_COUNT        = 16'h0000;
endpackage

// ### verilog/peripheral_dma_channel_control.sv
// channel control of a peripheral dma engine: pointers, counters, enables
// Notes on behaviour
// - a 32-bit next transmit address register holds the following tx buffer.
// - next transmit count is 16 bits in 15:0; upper bits read zero.
// - in half duplex, next rx and next tx address are one shared value.
// - in half duplex, next rx and next tx count are one shared value.
// - command bit 0 enables rx requests unless bit 1 is set too.
// - command bit 1 disables rx requests; zero has no effect.
// - command bit 8 enables tx requests unless bit 9 is set too; zero has no effect.
// - command bit 9 disables tx requests; zero has no effect.
// - in half duplex, enabling rx requests disables tx requests.
// - in half duplex, tx enable acts only without rx enable in same write.
// - in half duplex, rx disable also disables tx requests.
// - in half duplex, tx disable also disables rx requests.
// - status bit 0 shows rx requests enabled.
// - status bit 8 shows tx requests enabled.
// - zero current count stops a direction; nonzero moves data when enabled.
// - a next receive address register holds the following rx buffer.
`timescale 1ns/1ps
module peripheral_dma_channel_control
  import pdma_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_write,
  input  wire logic        reg_read,
  output logic      [31:0] reg_rdata,
  // peripheral side: one beat moved per request while active
  input  wire logic        rx_beat,
  input  wire logic        tx_beat,
  output logic             rx_active,
  output logic             tx_active,
  output logic      [31:0] rx_beat_addr,
  output logic      [31:0] tx_beat_addr
);

  logic [31:0] rx_addr, tx_addr, nrx_addr, ntx_addr;
  logic [15:0] rx_cnt, tx_cnt, nrx_cnt, ntx_cnt;
  logic        rx_en, tx_en, half;
  logic [31:0] next_rx_addr, next_tx_addr, next_nrx_addr, next_ntx_addr;
  logic [15:0] next_rx_cnt, next_tx_cnt, next_nrx_cnt, next_ntx_cnt;
  logic        next_rx_en, next_tx_en, next_half;
  logic [31:0] next_rdata;
  logic        next_rx_active, next_tx_active;
  logic        rx_beat_s1, rx_beat_s2, tx_beat_s1, tx_beat_s2;
  logic        cmd_write;

  assign cmd_write = reg_write && (reg_addr == OFF_COMMAND);

  // assertions below share one clock and reset
  default clocking assert_clk @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  function automatic logic hit(input logic [7:0] off);
    return reg_write && (reg_addr == off);
  endfunction

  // peripheral requests come from outside this clock domain
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_beat_s1 <= 1'b0;
      rx_beat_s2 <= 1'b0;
      tx_beat_s1 <= 1'b0;
      tx_beat_s2 <= 1'b0;
    end else begin
      rx_beat_s1 <= rx_beat;
      rx_beat_s2 <= rx_beat_s1;
      tx_beat_s1 <= tx_beat;
      tx_beat_s2 <= tx_beat_s1;
    end
  end

  always_comb begin
    logic c_rxe, c_rxd, c_txe, c_txd;
    c_rxe = 1'b0;
    c_rxd = 1'b0;
    c_txe = 1'b0;
    c_txd = 1'b0;
    next_rx_addr  = rx_addr;
    next_tx_addr  = tx_addr;
    next_nrx_addr = nrx_addr;
    next_ntx_addr = ntx_addr;
    next_rx_cnt   = rx_cnt;
    next_tx_cnt   = tx_cnt;
    next_nrx_cnt  = nrx_cnt;
    next_ntx_cnt  = ntx_cnt;
    next_rx_en    = rx_en;
    next_tx_en    = tx_en;
    next_half     = half;
    // data movement: a beat advances address and counts down
    if (rx_active && rx_beat_s2) begin
      next_rx_addr = rx_addr + 32'h0000_0001;
      next_rx_cnt  = rx_cnt - 16'h0001;
    end
    if (tx_active && tx_beat_s2) begin
      next_tx_addr = tx_addr + 32'h0000_0001;
      next_tx_cnt  = tx_cnt - 16'h0001;
    end
    // chain in the next buffer once the current one is done
    if (rx_cnt == RST_COUNT && nrx_cnt != RST_COUNT) begin
      next_rx_addr = nrx_addr;
      next_rx_cnt  = nrx_cnt;
      next_nrx_cnt = RST_COUNT;
      if (half) next_ntx_cnt = RST_COUNT;
    end
    if (tx_cnt == RST_COUNT && ntx_cnt != RST_COUNT) begin
      next_tx_addr = ntx_addr;
      next_tx_cnt  = ntx_cnt;
      next_ntx_cnt = RST_COUNT;
      if (half) next_nrx_cnt = RST_COUNT;
    end
    // register writes; half duplex keeps one shared next pair for both directions
    if (hit(OFF_RX_ADDR)) next_rx_addr = reg_wdata;
    if (hit(OFF_TX_ADDR)) next_tx_addr = reg_wdata;
    if (hit(OFF_RX_COUNT)) next_rx_cnt = reg_wdata[15:0];
    if (hit(OFF_TX_COUNT)) next_tx_cnt = reg_wdata[15:0];
    if (hit(OFF_NEXT_RX_ADDR) || (half && hit(OFF_NEXT_TX_ADDR)))
      next_nrx_addr = reg_wdata;
    if (hit(OFF_NEXT_TX_ADDR) || (half && hit(OFF_NEXT_RX_ADDR)))
      next_ntx_addr = reg_wdata;
    if (hit(OFF_NEXT_RX_CNT) || (half && hit(OFF_NEXT_TX_CNT)))
      next_nrx_cnt = reg_wdata[15:0];
    if (hit(OFF_NEXT_TX_CNT) || (half && hit(OFF_NEXT_RX_CNT)))
      next_ntx_cnt = reg_wdata[15:0];
    if (hit(OFF_MODE)) next_half = reg_wdata[BIT_HALF_DUPLEX];
    if (hit(OFF_COMMAND)) begin
      c_rxe = reg_wdata[BIT_RX_EN];
      c_rxd = reg_wdata[BIT_RX_DIS];
      c_txe = reg_wdata[BIT_TX_EN];
      c_txd = reg_wdata[BIT_TX_DIS];
    end
    if (c_rxe && !c_rxd) next_rx_en = 1'b1;
    if (c_rxd) next_rx_en = 1'b0;
    if (c_txe && !(half && c_rxe)) next_tx_en = 1'b1;
    if (c_txd) next_tx_en = 1'b0;
    if (half) begin
      if (c_rxe && !c_rxd) next_tx_en = 1'b0;
      if (c_rxd) next_tx_en = 1'b0;
      if (c_txd) next_rx_en = 1'b0;
    end
  end

  always_comb begin
    next_rdata = 32'h0000_0000;
    if (reg_read) begin
      case (reg_addr)
        OFF_RX_ADDR:      next_rdata = rx_addr;
        OFF_RX_COUNT:     next_rdata = {16'h0000, rx_cnt};
        OFF_TX_ADDR:      next_rdata = tx_addr;
        OFF_TX_COUNT:     next_rdata = {16'h0000, tx_cnt};
        OFF_NEXT_RX_ADDR: next_rdata = nrx_addr;
        OFF_NEXT_RX_CNT:  next_rdata = {16'h0000, nrx_cnt};
        OFF_NEXT_TX_ADDR: next_rdata = ntx_addr;
        OFF_NEXT_TX_CNT:  next_rdata = {16'h0000, ntx_cnt};
        OFF_MODE:         next_rdata = {31'h0000_0000, half};
        OFF_STATUS: begin
          next_rdata[BIT_RX_EN] = rx_en;
          next_rdata[BIT_TX_EN] = tx_en;
        end
        default:          next_rdata = 32'h0000_0000;
      endcase
    end
    next_rx_active = next_rx_en && next_rx_cnt != RST_COUNT;
    next_tx_active = next_tx_en && next_tx_cnt != RST_COUNT;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_addr      <= RST_ADDR;
      tx_addr      <= RST_ADDR;
      nrx_addr     <= RST_ADDR;
      ntx_addr     <= RST_ADDR;
      rx_cnt       <= RST_COUNT;
      tx_cnt       <= RST_COUNT;
      nrx_cnt      <= RST_COUNT;
      ntx_cnt      <= RST_COUNT;
      rx_en        <= 1'b0;
      tx_en        <= 1'b0;
      half         <= 1'b0;
      reg_rdata    <= 32'h0000_0000;
      rx_active    <= 1'b0;
      tx_active    <= 1'b0;
      rx_beat_addr <= RST_ADDR;
      tx_beat_addr <= RST_ADDR;
    end else begin
      rx_addr      <= next_rx_addr;
      tx_addr      <= next_tx_addr;
      nrx_addr     <= next_nrx_addr;
      ntx_addr     <= next_ntx_addr;
      rx_cnt       <= next_rx_cnt;
      tx_cnt       <= next_tx_cnt;
      nrx_cnt      <= next_nrx_cnt;
      ntx_cnt      <= next_ntx_cnt;
      rx_en        <= next_rx_en;
      tx_en        <= next_tx_en;
      half         <= next_half;
      reg_rdata    <= next_rdata;
      rx_active    <= next_rx_active;
      tx_active    <= next_tx_active;
      rx_beat_addr <= next_rx_addr;
      tx_beat_addr <= next_tx_addr;
    end
  end

  // assertions
  sequence rx_on_cmd;
    cmd_write && reg_wdata[BIT_RX_EN] && !reg_wdata[BIT_RX_DIS];
  endsequence
  sequence rx_step;
    rx_active && rx_beat_s2 && !reg_write;
  endsequence
  sequence tx_step;
    tx_active && tx_beat_s2 && !reg_write;
  endsequence
  // current buffer spent while a next one waits
  sequence rx_chain_due;
    rx_cnt == RST_COUNT && nrx_cnt != RST_COUNT && !reg_write;
  endsequence
  sequence tx_chain_due;
    tx_cnt == RST_COUNT && ntx_cnt != RST_COUNT && !reg_write;
  endsequence

  // enable and disable commands
  rx_enable_cmd_a: assert property (rx_on_cmd |=> rx_en)
    else $error("rx enable command ignored");
  rx_disable_cmd_a: assert property (
    cmd_write && reg_wdata[BIT_RX_DIS] |=> !rx_en)
    else $error("rx disable command ignored");
  tx_enable_cmd_a: assert property (
    cmd_write && reg_wdata[BIT_TX_EN] && !reg_wdata[BIT_TX_DIS] && !half
    |=> tx_en) else $error("tx enable command ignored");
  tx_disable_cmd_a: assert property (
    cmd_write && reg_wdata[BIT_TX_DIS] |=> !tx_en)
    else $error("tx disable command ignored");

  // half duplex interlocks
  half_rx_wins_a: assert property ((half and rx_on_cmd) |=> !tx_en)
    else $error("tx still on after rx enable");
  half_tx_enable_a: assert property (
    half && cmd_write && reg_wdata[BIT_TX_EN] && !reg_wdata[BIT_TX_DIS]
    && !reg_wdata[BIT_RX_EN] && !reg_wdata[BIT_RX_DIS] |=> tx_en)
    else $error("tx enable refused without rx enable");
  half_rx_off_a: assert property (
    half && cmd_write && reg_wdata[BIT_RX_DIS] |=> !tx_en)
    else $error("tx on after rx disable");
  half_tx_off_a: assert property (
    half && cmd_write && reg_wdata[BIT_TX_DIS] |=> !rx_en)
    else $error("rx on after tx disable");
  shared_next_a: assert property (
    half && reg_write && reg_addr == OFF_NEXT_TX_ADDR |=>
    nrx_addr == ntx_addr) else $error("next address not shared");
  shared_count_a: assert property (
    half && reg_write && reg_addr == OFF_NEXT_RX_CNT |=>
    nrx_cnt == ntx_cnt) else $error("next count not shared");
  half_chain_shared_a: assert property ((half and rx_chain_due) |=>
    ntx_cnt == RST_COUNT) else $error("shared next count kept after chain");

  // register contents
  status_read_a: assert property (
    reg_read && reg_addr == OFF_STATUS |=>
    reg_rdata == {23'h00_0000, $past(tx_en), 7'h00, $past(rx_en)})
    else $error("status read mismatch");
  next_tx_addr_a: assert property (
    reg_write && reg_addr == OFF_NEXT_TX_ADDR
    |=> ntx_addr == $past(reg_wdata))
    else $error("next tx address not written");
  next_tx_count_a: assert property (
    reg_write && reg_addr == OFF_NEXT_TX_CNT
    |=> ntx_cnt == $past(reg_wdata[15:0]))
    else $error("next tx count not written");
  count_upper_a: assert property (
    reg_read && reg_addr == OFF_NEXT_TX_CNT |=> reg_rdata[31:16] == 16'h0000)
    else $error("next tx count upper bits not zero");
  next_rx_addr_a: assert property (
    reg_write && reg_addr == OFF_NEXT_RX_ADDR
    |=> nrx_addr == $past(reg_wdata))
    else $error("next rx address not written");

  // data movement and chaining
  zero_stops_a: assert property (rx_cnt == RST_COUNT |-> !rx_active)
    else $error("rx moves at zero");
  tx_zero_stops_a: assert property (tx_cnt == RST_COUNT |-> !tx_active)
    else $error("tx moves at zero");
  rx_beat_step_a: assert property (rx_step |=>
    rx_cnt == $past(rx_cnt) - 16'h0001
    && rx_addr == $past(rx_addr) + 32'h0000_0001)
    else $error("rx beat did not advance");
  tx_beat_step_a: assert property (tx_step |=>
    tx_cnt == $past(tx_cnt) - 16'h0001
    && tx_addr == $past(tx_addr) + 32'h0000_0001)
    else $error("tx beat did not advance");
  rx_chain_load_a: assert property (rx_chain_due |=>
    rx_cnt == $past(nrx_cnt) && nrx_cnt == RST_COUNT)
    else $error("next rx buffer not chained");
  chain_load_a: assert property (tx_chain_due |=>
    tx_cnt == $past(ntx_cnt) && ntx_cnt == RST_COUNT)
    else $error("next buffer not chained");
endmodule

// ### test/beat_source.sv
// peripheral stand-in that asks for one beat every eighth cycle while active
`timescale 1ns/1ps
module beat_source (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // channel handshake
  input  wire logic active,
  output logic      beat
);
  logic [2:0] gap;
  // spacing of eight keeps beats clear of the two-stage input sync
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      gap  <= 3'h0;
      beat <= 1'b0;
    end else begin
      gap  <= active ? gap + 3'h1 : 3'h0;
      beat <= active && gap == 3'h7;
    end
  end
endmodule

// ### test/test_peripheral_dma_channel_control.sv
// self-checking bench for the dma channel control block
`timescale 1ns/1ps
module test_peripheral_dma_channel_control;
  import pdma_pkg::*;
  logic        clk       = 1'b0;
  logic        rst_n     = 1'b0;
  logic [7:0]  reg_addr  = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic        reg_write = 1'b0;
  logic        reg_read  = 1'b0;
  logic [31:0] reg_rdata;
  logic        rx_beat;
  logic        tx_beat;
  logic        rx_active;
  logic        tx_active;
  logic [31:0] rx_beat_addr;
  logic [31:0] tx_beat_addr;
  int          failures  = 0;
  int          compares  = 0;
  int          nbeats    = 0;

  peripheral_dma_channel_control u_peripheral_dma_channel_control (
    .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .rx_beat(rx_beat), .tx_beat(tx_beat), .rx_active(rx_active),
    .tx_active(tx_active), .rx_beat_addr(rx_beat_addr),
    .tx_beat_addr(tx_beat_addr));
  beat_source u_beat_source_rx (
    .clk(clk), .rst_n(rst_n), .active(rx_active), .beat(rx_beat));
  beat_source u_beat_source_tx (
    .clk(clk), .rst_n(rst_n), .active(tx_active), .beat(tx_beat));

  initial begin
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (rx_beat === 1'b1) nbeats++;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h, want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask

  task automatic t_reset;
    #1;
    chk({30'h0, rx_active, tx_active}, 32'h0000_0000);
    rd(OFF_STATUS, 32'h0000_0000);
  endtask
  task automatic t_regs;
    wr(OFF_TX_COUNT, 32'h0000_0001);
    wr(OFF_RX_COUNT, 32'h0000_0001);
    wr(OFF_NEXT_TX_ADDR, 32'hA5C3_0F18);
    wr(OFF_NEXT_RX_ADDR, 32'h1234_5678);
    rd(OFF_NEXT_TX_ADDR, 32'hA5C3_0F18);
    rd(OFF_NEXT_RX_ADDR, 32'h1234_5678);
    wr(OFF_NEXT_TX_CNT, 32'hFFFF_ABCD);
    rd(OFF_NEXT_TX_CNT, 32'h0000_ABCD);
    rd(8'h3C, 32'h0000_0000);
  endtask
  task automatic t_full;
    wr(OFF_COMMAND, 32'h0000_0003);
    rd(OFF_STATUS, 32'h0000_0000);
    wr(OFF_COMMAND, 32'h0000_0001);
    rd(OFF_STATUS, 32'h0000_0001);
    wr(OFF_COMMAND, 32'h0000_0100);
    rd(OFF_STATUS, 32'h0000_0101);
    wr(OFF_COMMAND, 32'h0000_0000);
    wr(OFF_STATUS, 32'h0000_0000);
    rd(OFF_STATUS, 32'h0000_0101);
    rd(OFF_COMMAND, 32'h0000_0000);
    wr(OFF_COMMAND, 32'h0000_0200);
    rd(OFF_STATUS, 32'h0000_0001);
    wr(OFF_COMMAND, 32'h0000_0002);
    rd(OFF_STATUS, 32'h0000_0000);
  endtask
  task automatic t_half;
    wr(OFF_MODE, 32'h0000_0001);
    wr(OFF_NEXT_TX_ADDR, 32'h0BAD_F00D);
    rd(OFF_NEXT_RX_ADDR, 32'h0BAD_F00D);
    wr(OFF_RX_COUNT, 32'h0000_0001);
    wr(OFF_NEXT_RX_CNT, 32'h0000_0033);
    rd(OFF_NEXT_TX_CNT, 32'h0000_0033);
    // spending rx consumes the shared next count for both directions
    wr(OFF_RX_COUNT, 32'h0000_0000);
    rd(OFF_NEXT_TX_CNT, 32'h0000_0000);
    rd(OFF_RX_COUNT, 32'h0000_0033);
    wr(OFF_COMMAND, 32'h0000_0100);
    wr(OFF_COMMAND, 32'h0000_0002);
    rd(OFF_STATUS, 32'h0000_0000);
    wr(OFF_COMMAND, 32'h0000_0100);
    wr(OFF_COMMAND, 32'h0000_0001);
    rd(OFF_STATUS, 32'h0000_0001);
    wr(OFF_COMMAND, 32'h0000_0200);
    rd(OFF_STATUS, 32'h0000_0000);
    wr(OFF_COMMAND, 32'h0000_0100);
    rd(OFF_STATUS, 32'h0000_0100);
    wr(OFF_COMMAND, 32'h0000_0202);
    wr(OFF_MODE, 32'h0000_0000);
  endtask
  task automatic t_chain;
    int quiet;
    quiet = 0;
    wr(OFF_RX_ADDR, 32'h0000_1000);
    wr(OFF_RX_COUNT, 32'h0000_0002);
    wr(OFF_NEXT_RX_ADDR, 32'h0000_2000);
    wr(OFF_NEXT_RX_CNT, 32'h0000_0001);
    nbeats = 0;
    wr(OFF_COMMAND, 32'h0000_0001);
    repeat (2) @(posedge clk);
    #1;
    chk({31'h0, rx_active}, 32'h0000_0001);
    // wait for a lasting idle, bridging the reload gap
    for (int i = 0; i < 400 && quiet < 20; i++) begin
      @(posedge clk);
      quiet = (rx_active === 1'b0) ? quiet + 1 : 0;
    end
    chk(nbeats, 32'h0000_0003);
    rd(OFF_RX_COUNT, 32'h0000_0000);
    rd(OFF_NEXT_RX_CNT, 32'h0000_0000);
    rd(OFF_RX_ADDR, 32'h0000_2001);
    chk(rx_beat_addr, 32'h0000_2001);
    wr(OFF_NEXT_TX_CNT, 32'h0000_0000);
    wr(OFF_TX_ADDR, 32'h0000_3000);
    wr(OFF_TX_COUNT, 32'h0000_0001);
    wr(OFF_COMMAND, 32'h0000_0100);
    repeat (30) @(posedge clk);
    #1;
    chk({31'h0, tx_active}, 32'h0000_0000);
    chk(tx_beat_addr, 32'h0000_3001);
    wr(OFF_COMMAND, 32'h0000_0200);
  endtask

  task automatic final_report;
    if (failures == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    #100000;
    failures++;
    final_report;
  end
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    t_reset;
    t_regs;
    t_full;
    t_half;
    t_chain;
    final_report;
  end
endmodule
